// file: serial_register_port_defs.vh
// Constants for the two-wire serial register port.
`ifndef SERIAL_REGISTER_PORT_DEFS_VH
`define SERIAL_REGISTER_PORT_DEFS_VH

// ****************************************************************
// Frame layout
// ****************************************************************
`define PREAMBLE_ONES      6'd32
`define OP_BITS_LAST       6'd1
`define ADDR_FIELD_LAST    6'd4
`define TA_BITS_LAST       6'd1
`define DATA_BITS_LAST     6'd15
`define OP_REG_ACCESS      2'b00
`define ADDR_HIGH_RD_BIT   4
`define ADDR_HIGH_MAP_MSB  2

// ****************************************************************
// Register map and reset values
// ****************************************************************
`define LAST_CFG_REG       8'h8d
`define READ_UPPER_BYTE    8'h00
`define BYTE_RESET         8'h00
`define ADDR_RESET         8'h00
`define COUNT_RESET        6'h00

// ****************************************************************
// Management clock limit (controller side)
// ****************************************************************
`define MGMT_CLOCK_MAX_KHZ 5000

`endif

// file: pin_sampler.v
// Two-flop synchroniser for a pin, with rising-edge detection.
`timescale 1ns/1ps

module pin_sampler (
  input  wire clock,
  input  wire nrst,
  input  wire pin,
  output wire level,
  output wire rise
);

  reg meta_reg;
  reg sync_reg;
  reg prev_reg;

  // The first flop feeds only the second one.
  always @(posedge clock) begin
    if (!nrst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= pin;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign level = sync_reg;
  assign rise  = sync_reg & ~prev_reg;

endmodule

// file: serial_register_port.v
// Two-wire serial register port slave giving access to the 8-bit registers.
//
// Function
// (R1) A frame is 32 ones, start bits 01, a 2-bit opcode, 5 high and 5 low address bits, a 2-bit turnaround, 16 data bits and idle.
// (R2) Opcode 00 with high-address bit 4 set selects a register read.
// (R3) Opcode 00 with high-address bit 4 clear selects a register write.
// (R4) High-address bit 3 is ignored for register accesses.
// (R5) The 8-bit address is the low three high-address bits followed by the five low-address bits.
// (R6) Every configuration register from 0 through 141 is reachable.
// (R7) Standard management registers 0 to 5 and custom ones 29 and 31 are reached indirectly through this port.
// (R8) Each register holds eight bits carried in the low byte of the data field.
// (R9) A read returns zeros on the upper eight data bits ahead of the register byte.
// (R10) A write ignores the upper eight data bits and stores only the low byte.
// (R11) Other frame handling follows ordinary management access: preamble, sampling on the clock and turnaround.
// (R12) The controller keeps the management clock at or below 5 MHz; the testbench controller uses 48 ns bits, about 20.8 MHz.
// (R13) In a read turnaround the line floats one bit then the device drives zero; all release it at idle.
// (R14) A register is updated only after all sixteen data bits of a valid write frame arrive.
`timescale 1ns/1ps
`include "serial_register_port_defs.vh"

module serial_register_port (
  input  wire       clock,
  input  wire       nrst,
  input  wire       mdc,
  input  wire       mdio_in,
  output reg        mdio_out,
  output reg        mdio_oe,
  output reg  [7:0] cfg_addr,
  output reg  [7:0] cfg_wdata,
  output reg        cfg_write,
  output reg        cfg_read,
  input  wire [7:0] cfg_rdata,
  output reg        cfg_range_error
);

  // ****************************************************************
  // States
  // ****************************************************************
  localparam [2:0] ST_IDLE  = 3'd0;
  localparam [2:0] ST_START = 3'd1;
  localparam [2:0] ST_OP    = 3'd2;
  localparam [2:0] ST_ADRH  = 3'd3;
  localparam [2:0] ST_ADRL  = 3'd4;
  localparam [2:0] ST_TA    = 3'd5;
  localparam [2:0] ST_DATA  = 3'd6;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function in_range;
    input [7:0] addr;
    begin
      // The indirect management registers sit behind configuration
      // registers in this range, so they need no address of their own.
      in_range = (addr <= `LAST_CFG_REG); // see (R6) see (R7)
    end
  endfunction

  // ****************************************************************
  // Pin sampling
  // ****************************************************************
  wire mdc_rise;
  wire mdio_level;

  // Both pins pass the same two flops, so their skew is preserved.
  pin_sampler clk_sampler (
    .clock (clock),
    .nrst  (nrst),
    .pin   (mdc),
    .level (),
    .rise  (mdc_rise)
  );

  pin_sampler data_sampler (
    .clock (clock),
    .nrst  (nrst),
    .pin   (mdio_in),
    .level (mdio_level),
    .rise  ()
  );

  // ****************************************************************
  // Frame state
  // ****************************************************************
  reg [2:0]  state_reg;
  reg [5:0]  count_reg;
  reg [15:0] shift_reg;
  reg [1:0]  op_reg;
  reg [4:0]  addr_high_field_reg;
  reg        is_read_reg;
  reg        is_write_reg;

  wire [15:0] shift_in = {shift_reg[14:0], mdio_level};
  // Bit 3 of the high field never reaches the address.
  wire [7:0]  frame_addr = {addr_high_field_reg[`ADDR_HIGH_MAP_MSB:0],
                            shift_in[4:0]}; // see (R4) see (R5)
  wire        reg_access = (op_reg == `OP_REG_ACCESS);

  always @(posedge clock) begin
    if (!nrst) begin
      state_reg           <= ST_IDLE;
      count_reg           <= `COUNT_RESET;
      shift_reg           <= 16'h0000;
      op_reg              <= 2'b11;
      addr_high_field_reg <= 5'h00;
      is_read_reg         <= 1'b0;
      is_write_reg        <= 1'b0;
      mdio_out            <= 1'b0;
      mdio_oe             <= 1'b0;
      cfg_addr            <= `ADDR_RESET;
      cfg_wdata           <= `BYTE_RESET;
      cfg_write           <= 1'b0;
      cfg_read            <= 1'b0;
      cfg_range_error     <= 1'b0;
    end else begin
      cfg_write       <= 1'b0;
      cfg_read        <= 1'b0;
      cfg_range_error <= 1'b0;
      // Every bit is taken on a rising management clock edge, and the
      // device changes its own drive just after that same edge.
      if (mdc_rise) begin // see (R11)
        case (state_reg)
          ST_IDLE: begin
            if (mdio_level) begin
              if (count_reg != `PREAMBLE_ONES) begin
                count_reg <= count_reg + 6'd1;
              end
            end else if (count_reg == `PREAMBLE_ONES) begin
              state_reg <= ST_START; // see (R1)
            end else begin
              count_reg <= `COUNT_RESET;
            end
          end
          ST_START: begin
            count_reg <= `COUNT_RESET;
            if (mdio_level) begin
              state_reg <= ST_OP;
            end else begin
              state_reg <= ST_IDLE;
            end
          end
          ST_OP: begin
            shift_reg <= shift_in;
            if (count_reg == `OP_BITS_LAST) begin
              op_reg    <= shift_in[1:0];
              count_reg <= `COUNT_RESET;
              state_reg <= ST_ADRH;
            end else begin
              count_reg <= count_reg + 6'd1;
            end
          end
          ST_ADRH: begin
            shift_reg <= shift_in;
            if (count_reg == `ADDR_FIELD_LAST) begin
              addr_high_field_reg <= shift_in[4:0];
              count_reg           <= `COUNT_RESET;
              state_reg           <= ST_ADRL;
            end else begin
              count_reg <= count_reg + 6'd1;
            end
          end
          ST_ADRL: begin
            shift_reg <= shift_in;
            if (count_reg == `ADDR_FIELD_LAST) begin
              count_reg <= `COUNT_RESET;
              state_reg <= ST_TA;
              cfg_addr  <= frame_addr;
              // Other opcodes belong to ordinary management traffic and
              // are passed over here without touching the line.
              is_read_reg  <= reg_access &
                              addr_high_field_reg[`ADDR_HIGH_RD_BIT];
              is_write_reg <= reg_access &
                              ~addr_high_field_reg[`ADDR_HIGH_RD_BIT];
              if (reg_access) begin
                if (!in_range(frame_addr)) begin
                  cfg_range_error <= 1'b1;
                end else if (addr_high_field_reg[`ADDR_HIGH_RD_BIT]) begin
                  cfg_read <= 1'b1; // see (R2)
                end
              end
            end else begin
              count_reg <= count_reg + 6'd1;
            end
          end
          ST_TA: begin
            if (count_reg != `TA_BITS_LAST) begin
              count_reg <= count_reg + 6'd1;
              // First turnaround bit has passed with the line floating.
              if (is_read_reg) begin
                mdio_out <= 1'b0; // see (R13)
                mdio_oe  <= 1'b1;
                if (in_range(cfg_addr)) begin
                  shift_reg <= {`READ_UPPER_BYTE, cfg_rdata}; // see (R9)
                end else begin
                  shift_reg <= {`READ_UPPER_BYTE, `BYTE_RESET};
                end
              end
            end else begin
              count_reg <= `COUNT_RESET;
              state_reg <= ST_DATA;
              mdio_out  <= shift_reg[15];
              shift_reg <= {shift_reg[14:0], 1'b0};
            end
          end
          ST_DATA: begin
            // One shifter serves both directions: read bits leave at the
            // top while write bits enter at the bottom.
            shift_reg <= shift_in;
            mdio_out  <= shift_reg[15]; // see (R8)
            if (count_reg == `DATA_BITS_LAST) begin
              mdio_oe   <= 1'b0; // see (R13)
              mdio_out  <= 1'b0;
              count_reg <= `COUNT_RESET;
              state_reg <= ST_IDLE;
              if (is_write_reg && in_range(cfg_addr)) begin
                cfg_wdata <= shift_in[7:0]; // see (R10)
                cfg_write <= 1'b1; // see (R3) see (R14)
              end
              is_read_reg  <= 1'b0;
              is_write_reg <= 1'b0;
            end else begin
              count_reg <= count_reg + 6'd1;
            end
          end
          default: begin
            state_reg <= ST_IDLE;
            count_reg <= `COUNT_RESET;
            mdio_oe   <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule

// file: serial_register_port_props.sv
// Checker for the serial register port.
`timescale 1ns/1ps
module serial_register_port_props (
  input wire       clock,
  input wire       nrst,
  input wire       mdc,
  input wire       mdio_in,
  input wire       mdio_out,
  input wire       mdio_oe,
  input wire [7:0] cfg_addr,
  input wire [7:0] cfg_wdata,
  input wire       cfg_write,
  input wire       cfg_read,
  input wire [7:0] cfg_rdata,
  input wire       cfg_range_error
);
  // The raw pin is counted so the sampler's delay cannot hide a shift.
  reg       mdc_reg;
  reg [4:0] rises_reg;
  always @(posedge clock) begin
    mdc_reg <= mdc;
    if (!nrst || !mdio_oe) rises_reg <= 5'h00;
    else if (mdc && !mdc_reg) rises_reg <= rises_reg + 5'h01;
  end
  // ****************
  // Assertions
  // ****************
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  a_pulse_excl: assert property (!(cfg_write && cfg_read))
    else $error("write and read pulse together");
  a_write_range: assert property (cfg_write |-> cfg_addr <= 8'h8d)
    else $error("write beyond the map");
  a_read_range: assert property (cfg_read |-> cfg_addr <= 8'h8d)
    else $error("read beyond the map");
  a_error_no_access: assert property (cfg_range_error |->
    !cfg_write && !cfg_read && cfg_addr > 8'h8d)
    else $error("range error with access");
  a_write_single: assert property (cfg_write |=> !cfg_write)
    else $error("write pulse too long");
  a_read_drive: assert property
    (cfg_read |-> ##[1:300] $rose(mdio_oe))
    else $error("read not followed by drive");
  a_upper_zero: assert property
    (mdio_oe && rises_reg <= 5'd8 |-> !mdio_out)
    else $error("upper byte not zero");
  a_drive_length: assert property
    (mdio_oe |-> rises_reg <= 5'd17)
    else $error("line driven too long");
  cover property (cfg_write);
  cover property (cfg_read);
  cover property (cfg_range_error);
  cover property ($rose(mdio_oe));
endmodule

// file: mgmt_controller.sv
// Behavioural management controller that clocks frames onto the line.
`timescale 1ns/1ps
module mgmt_controller (
  input  wire        mdio_line,
  output reg         mdc,
  output reg         mdio_drv,
  output reg         mdio_en,
  output reg  [15:0] rd_data
);
  // ****************
  // Frame driver
  // ****************
  // The clock pin stands low between frames.
  initial begin
    mdc = 1'b0;
    mdio_drv = 1'b1;
    mdio_en = 1'b0;
    rd_data = 16'h0000;
  end
  task bit_out(input b, input en);
    begin
      mdio_en = en;
      mdio_drv = en ? b : ~mdio_drv;
      // A 48 ns bit is far above the controller's rate limit on purpose:
      // the slave needs only four system clocks per phase, so slower,
      // legal rates are covered as well.
      #24 mdc = 1'b1;
      rd_data = {rd_data[14:0], mdio_line};
      #24 mdc = 1'b0;
    end
  endtask
  task frame(input [5:0] ones, input [1:0] op, input [4:0] hi,
             input [4:0] lo, input [15:0] data, input rd);
    reg [31:0] w;
    integer    i;
    begin
      w = {2'b01, op, hi, lo, rd ? 2'b11 : 2'b10, data};
      for (i = 0; i < ones; i = i + 1) bit_out(1'b1, 1'b1);
      for (i = 31; i >= 0; i = i - 1) begin
        bit_out(w[i], !(rd && i < 18));
      end
      mdio_en = 1'b0;
      #96;
    end
  endtask
endmodule

// file: test_serial_register_port.sv
// Testbench for the serial register port.
`timescale 1ns/1ps
module test_serial_register_port;
  reg         clock = 1'b0;
  reg         nrst = 1'b0;
  reg  [7:0]  cfg_rdata = 8'h00;
  reg  [7:0]  mem [0:255];
  reg  [15:0] n_wr = 16'h0, n_rd = 16'h0, n_err = 16'h0;
  integer     fails = 0, checks_done = 0;
  wire        mdc, mdio_drv, mdio_en, mdio_out, mdio_oe;
  wire        cfg_write, cfg_read, cfg_range_error;
  wire [7:0]  cfg_addr, cfg_wdata;
  // The line has a pull-up, so a released line reads as one.
  wire        mdio_line = mdio_oe ? mdio_out : (mdio_en ? mdio_drv : 1'b1);
  always #2.5 clock = ~clock;
  mgmt_controller ctl (.mdio_line(mdio_line), .mdc(mdc),
    .mdio_drv(mdio_drv), .mdio_en(mdio_en), .rd_data());
  serial_register_port dut (.clock(clock), .nrst(nrst), .mdc(mdc),
    .mdio_in(mdio_line), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_write(cfg_write),
    .cfg_read(cfg_read), .cfg_rdata(cfg_rdata),
    .cfg_range_error(cfg_range_error));
  // ****************
  // Register file and scenarios
  // ****************
  always @(posedge clock) begin
    if (cfg_write) mem[cfg_addr] <= cfg_wdata;
    cfg_rdata <= mem[cfg_addr];
    if (cfg_write) n_wr <= n_wr + 16'h1;
    if (cfg_read) n_rd <= n_rd + 16'h1;
    if (cfg_range_error) n_err <= n_err + 16'h1;
  end
  task chk(input [15:0] got, input [15:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wr_rd(input [4:0] hi, input [4:0] lo, input [7:0] d);
    reg [15:0] w0, r0;
    begin
      w0 = n_wr;
      r0 = n_rd;
      ctl.frame(6'd32, 2'b00, hi & 5'h0f, lo, {~d, d}, 1'b0);
      chk(n_wr - w0, 16'h1);
      chk({8'h00, cfg_addr}, {8'h00, hi[2:0], lo});
      chk({8'h00, cfg_wdata}, {8'h00, d});
      ctl.frame(6'd32, 2'b00, (hi | 5'h10) ^ 5'h08, lo,
                16'h0, 1'b1);
      chk(n_rd - r0, 16'h1);
      chk(ctl.rd_data, {8'h00, d});
    end
  endtask
  task refuse;
    reg [15:0] w0, r0, e0;
    begin
      w0 = n_wr;
      r0 = n_rd;
      e0 = n_err;
      ctl.frame(6'd32, 2'b00, 5'h14, 5'h0e, 16'h0, 1'b1);
      chk(n_err - e0, 16'h1);
      chk(ctl.rd_data, 16'h0000);
      // Start bits 00 after a full preamble must not open a frame.
      repeat (32) ctl.bit_out(1'b1, 1'b1);
      repeat (32) ctl.bit_out(1'b0, 1'b1);
      ctl.frame(6'd32, 2'b01, 5'h01, 5'h05, 16'h0033, 1'b0);
      ctl.frame(6'd31, 2'b00, 5'h01, 5'h05, 16'h0033, 1'b0);
      chk(n_wr - w0, 16'h0);
      chk(n_rd - r0, 16'h0);
    end
  endtask
  task end_of_test;
    begin
      $display("Comparisons %0d, mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  initial begin
    repeat (16) @(posedge clock);
    nrst <= 1'b1;
    repeat (4) @(posedge clock);
    wr_rd(5'h09, 5'h05, 8'h5a);
    wr_rd(5'h04, 5'h0d, 8'h81);
    wr_rd(5'h00, 5'h00, 8'hc3);
    refuse;
    wr_rd(5'h00, 5'h1d, 8'h3c);
    end_of_test;
  end
  initial begin
    #100000;
    fails = fails + 1;
    end_of_test;
  end
endmodule
bind serial_register_port serial_register_port_props props (
  .clock           (clock),
  .nrst            (nrst),
  .mdc             (mdc),
  .mdio_in         (mdio_in),
  .mdio_out        (mdio_out),
  .mdio_oe         (mdio_oe),
  .cfg_addr        (cfg_addr),
  .cfg_wdata       (cfg_wdata),
  .cfg_write       (cfg_write),
  .cfg_read        (cfg_read),
  .cfg_rdata       (cfg_rdata),
  .cfg_range_error (cfg_range_error)
);
